/* src/oag_top.sv */
// module: operand address generator with program counter update
`timescale 1ns/1ps
// How it works
// - form address, then read or write there, except in implied, literal and branch offset modes
// - implied mode: opcode only, one byte
// - literal: address pc plus one, pc+2
// - direct: zero high, operand low, pc+2
// - full address: high then low, pc+3
// - pointer: zero high, index low, pc+1
// - byte offset: index plus offset, carry high
// - word offset: index plus low, carry up
// - branch: pc+2 plus signed offset if taken
// - bit modify: bit from opcode, pc+2
// - bit modify reaches first page only
// - tested bit copied into carry flag
module oag_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire oag_pkg::oag_req_t req_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] rdata_i,
  output logic busy_o,
  output logic mem_req_o,
  output oag_pkg::oag_mem_t mem_o,
  output logic [15:0] pc_o,
  output logic [15:0] ea_o,
  output logic [7:0] operand_o,
  output logic operand_valid_o,
  output logic carry_o,
  output logic carry_we_o,
  output logic done_o
);
  // *****************************************
  // state
  // *****************************************
  typedef struct packed {
    oag_pkg::oag_state_t st;
    oag_pkg::oag_mode_t mode;
    logic [7:0] opcode;
    logic [7:0] index;
    logic cond;
    logic bitv;
    logic [1:0] need;
    logic [7:0] b1;
    logic [15:0] pc;
    logic [15:0] ea;
    logic [7:0] operand;
    logic opv;
    logic memreq;
    oag_pkg::oag_mem_t mem;
    logic carry;
    logic carry_we;
    logic done;
  } oag_regs_t;

  oag_regs_t r_q;
  oag_regs_t r_d;
  oag_pkg::oag_mode_t dec_mode;
  logic [1:0] dec_bytes;

  oag_mode_decode u_dec (
    .opcode_i(req_i.opcode),
    .mode_o(dec_mode),
    .operand_bytes_o(dec_bytes)
  );

  // sign-extend an 8-bit branch offset
  function automatic logic [15:0] oag_sext(input logic [7:0] b);
    oag_sext = {{8{b[7]}}, b};
  endfunction : oag_sext

  // *****************************************
  // next state
  // *****************************************
  always_comb begin
    logic [8:0] lsum;
    r_d = r_q;
    lsum = 9'h000;
    r_d.done = 1'b0;
    r_d.memreq = 1'b0;
    r_d.carry_we = 1'b0;
    unique case (r_q.st)
      oag_pkg::OAG_IDLE: begin
        r_d.opv = 1'b0;
        if (start_i) begin
          r_d.opcode = req_i.opcode;
          r_d.index = req_i.index;
          r_d.cond = req_i.cond_true;
          r_d.bitv = req_i.bit_value;
          r_d.mode = dec_mode;
          r_d.need = dec_bytes;
          if (dec_bytes == 2'd0) begin
            r_d.st = oag_pkg::OAG_ACCESS;
          end else begin
            r_d.st = oag_pkg::OAG_FETCH1;
            r_d.memreq = 1'b1;
            r_d.mem = '{addr: r_q.pc + oag_pkg::STEP_ONE, write: 1'b0, wdata: 8'h00};
          end
        end
      end
      oag_pkg::OAG_FETCH1: begin
        r_d.b1 = rdata_i;
        if (r_q.need == 2'd2) begin
          r_d.st = oag_pkg::OAG_FETCH2;
          r_d.memreq = 1'b1;
          r_d.mem = '{addr: r_q.pc + oag_pkg::STEP_TWO, write: 1'b0, wdata: 8'h00};
        end else begin
          r_d.st = oag_pkg::OAG_ACCESS;
        end
      end
      oag_pkg::OAG_FETCH2: begin
        r_d.st = oag_pkg::OAG_ACCESS;
        r_d.operand = rdata_i; // second operand byte parked
      end
      oag_pkg::OAG_ACCESS: begin
        r_d.st = oag_pkg::OAG_DONE;
        r_d.done = 1'b1;
        unique case (r_q.mode)
          oag_pkg::OAG_IMPLIED_OPERAND_MODE: begin
            r_d.ea = r_q.pc;
            r_d.pc = r_q.pc + oag_pkg::STEP_ONE;
          end
          oag_pkg::OAG_LITERAL_OPERAND_MODE: begin
            r_d.ea = r_q.pc + oag_pkg::STEP_ONE;
            r_d.operand = r_q.b1;
            r_d.opv = 1'b1;
            r_d.pc = r_q.pc + oag_pkg::STEP_TWO;
          end
          oag_pkg::OAG_DIRECT_MODE: begin
            r_d.ea = {oag_pkg::PAGE_ZERO, r_q.b1};
            r_d.pc = r_q.pc + oag_pkg::STEP_TWO;
          end
          oag_pkg::OAG_FULL_ADDRESS_MODE: begin
            r_d.ea = {r_q.b1, r_q.operand};
            r_d.pc = r_q.pc + oag_pkg::STEP_THREE;
          end
          oag_pkg::OAG_POINTER_MODE: begin
            r_d.ea = {oag_pkg::PAGE_ZERO, r_q.index};
            r_d.pc = r_q.pc + oag_pkg::STEP_ONE;
          end
          oag_pkg::OAG_POINTER_BYTE_OFFSET_MODE: begin
            lsum = {1'b0, r_q.index} + {1'b0, r_q.b1};
            r_d.ea = {7'h00, lsum};
            r_d.pc = r_q.pc + oag_pkg::STEP_TWO;
          end
          oag_pkg::OAG_POINTER_WORD_OFFSET_MODE: begin
            lsum = {1'b0, r_q.index} + {1'b0, r_q.operand};
            r_d.ea = {8'(r_q.b1 + {7'h00, lsum[8]}), lsum[7:0]};
            r_d.pc = r_q.pc + oag_pkg::STEP_THREE;
          end
          oag_pkg::OAG_BRANCH_OFFSET_MODE: begin
            r_d.ea = r_q.pc + oag_pkg::STEP_TWO + oag_sext(r_q.b1);
            r_d.pc = r_q.cond ? r_d.ea : r_q.pc + oag_pkg::STEP_TWO;
          end
          oag_pkg::OAG_SINGLE_BIT_MODIFY_MODE: begin
            r_d.ea = {oag_pkg::PAGE_ZERO, r_q.b1};
            r_d.pc = r_q.pc + oag_pkg::STEP_TWO;
          end
          oag_pkg::OAG_BIT_TEST_BRANCH_MODE: begin
            r_d.carry = r_q.bitv;
            r_d.carry_we = 1'b1;
            r_d.ea = {oag_pkg::PAGE_ZERO, r_q.b1};
            r_d.pc = r_q.cond ? r_q.pc + oag_pkg::STEP_THREE + oag_sext(r_q.operand)
                              : r_q.pc + oag_pkg::STEP_THREE;
          end
          default: r_d.pc = r_q.pc + oag_pkg::STEP_ONE;
        endcase
        if (r_q.mode != oag_pkg::OAG_IMPLIED_OPERAND_MODE && r_q.mode != oag_pkg::OAG_LITERAL_OPERAND_MODE
            && r_q.mode != oag_pkg::OAG_BRANCH_OFFSET_MODE) begin
          r_d.memreq = 1'b1;
          r_d.mem = '{addr: r_d.ea, write: (r_q.mode == oag_pkg::OAG_SINGLE_BIT_MODIFY_MODE), wdata: acc_i};
          if (r_q.mode == oag_pkg::OAG_SINGLE_BIT_MODIFY_MODE) begin
            r_d.mem.wdata = r_q.opcode[0] ? (acc_i & ~(8'h01 << r_q.opcode[3:1]))
                                          : (acc_i | (8'h01 << r_q.opcode[3:1]));
          end
        end
      end
      oag_pkg::OAG_DONE: begin
        r_d.st = oag_pkg::OAG_IDLE;
        if (r_q.memreq && !r_q.mem.write) begin
          r_d.operand = rdata_i;
          r_d.opv = 1'b1;
        end
      end
      default: r_d.st = oag_pkg::OAG_IDLE;
    endcase
  end

  // register stage, frozen by the clock enable
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_q <= '0;
      r_q.pc <= oag_pkg::RESET_PC;
    end else if (clk_en_i) begin
      r_q <= r_d;
    end
  end

  assign busy_o = (r_q.st != oag_pkg::OAG_IDLE);
  assign mem_req_o = r_q.memreq;
  assign mem_o = r_q.mem;
  assign pc_o = r_q.pc;
  assign ea_o = r_q.ea;
  assign operand_o = r_q.operand;
  assign operand_valid_o = r_q.opv;
  assign carry_o = r_q.carry;
  assign carry_we_o = r_q.carry_we;
  assign done_o = r_q.done;
endmodule : oag_top

/* src/oag_pkg.sv */
// package: constants and types for the operand address generator
package oag_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  localparam logic [15:0] STEP_THREE = 16'h0003;
  // opcode high nibbles that select a mode
  localparam logic [3:0] HI_BTB = 4'h0;
  localparam logic [3:0] HI_BSC = 4'h1;
  localparam logic [3:0] HI_REL = 4'h2;
  localparam logic [3:0] HI_DIR_RMW = 4'h3;
  localparam logic [3:0] HI_INH_A = 4'h4;
  localparam logic [3:0] HI_INH_X = 4'h5;
  localparam logic [3:0] HI_IX1_RMW = 4'h6;
  localparam logic [3:0] HI_IX_RMW = 4'h7;
  localparam logic [3:0] HI_CTL_A = 4'h8;
  localparam logic [3:0] HI_CTL_B = 4'h9;
  localparam logic [3:0] HI_IMM = 4'ha;
  localparam logic [3:0] HI_DIR = 4'hb;
  localparam logic [3:0] HI_EXT = 4'hc;
  localparam logic [3:0] HI_IX2 = 4'hd;
  localparam logic [3:0] HI_IX1 = 4'he;
  localparam logic [3:0] HI_IX = 4'hf;

  typedef enum logic [3:0] {
    OAG_IMPLIED_OPERAND_MODE = 4'h0,
    OAG_LITERAL_OPERAND_MODE = 4'h1,
    OAG_DIRECT_MODE = 4'h2,
    OAG_FULL_ADDRESS_MODE = 4'h3,
    OAG_POINTER_MODE = 4'h4,
    OAG_POINTER_BYTE_OFFSET_MODE = 4'h5,
    OAG_POINTER_WORD_OFFSET_MODE = 4'h6,
    OAG_BRANCH_OFFSET_MODE = 4'h7,
    OAG_SINGLE_BIT_MODIFY_MODE = 4'h8,
    OAG_BIT_TEST_BRANCH_MODE = 4'h9
  } oag_mode_t;

  typedef enum logic [2:0] {
    OAG_IDLE = 3'h0,
    OAG_FETCH1 = 3'h1,
    OAG_FETCH2 = 3'h2,
    OAG_ACCESS = 3'h3,
    OAG_DONE = 3'h4
  } oag_state_t;

  // one instruction request from decode
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] index;
    logic cond_true;
    logic bit_value;
  } oag_req_t;

  // one memory access toward the bus
  typedef struct packed {
    logic [15:0] addr;
    logic write;
    logic [7:0] wdata;
  } oag_mem_t;
endpackage : oag_pkg

/* src/oag_mode_decode.sv */
// module: opcode to addressing mode and operand-byte count decoder
`timescale 1ns/1ps
module oag_mode_decode (
  input wire logic [7:0] opcode_i,
  output oag_pkg::oag_mode_t mode_o,
  output logic [1:0] operand_bytes_o
);
  always_comb begin
    mode_o = oag_pkg::OAG_IMPLIED_OPERAND_MODE;
    unique case (opcode_i[7:4])
      oag_pkg::HI_BTB: mode_o = oag_pkg::OAG_BIT_TEST_BRANCH_MODE;
      oag_pkg::HI_BSC: mode_o = oag_pkg::OAG_SINGLE_BIT_MODIFY_MODE;
      oag_pkg::HI_REL: mode_o = oag_pkg::OAG_BRANCH_OFFSET_MODE;
      oag_pkg::HI_DIR_RMW, oag_pkg::HI_DIR: mode_o = oag_pkg::OAG_DIRECT_MODE;
      oag_pkg::HI_INH_A, oag_pkg::HI_INH_X, oag_pkg::HI_CTL_A, oag_pkg::HI_CTL_B:
        mode_o = oag_pkg::OAG_IMPLIED_OPERAND_MODE;
      oag_pkg::HI_IX1_RMW, oag_pkg::HI_IX1: mode_o = oag_pkg::OAG_POINTER_BYTE_OFFSET_MODE;
      oag_pkg::HI_IX_RMW, oag_pkg::HI_IX: mode_o = oag_pkg::OAG_POINTER_MODE;
      oag_pkg::HI_IMM: mode_o = oag_pkg::OAG_LITERAL_OPERAND_MODE;
      oag_pkg::HI_EXT: mode_o = oag_pkg::OAG_FULL_ADDRESS_MODE;
      oag_pkg::HI_IX2: mode_o = oag_pkg::OAG_POINTER_WORD_OFFSET_MODE;
    endcase
  end

  // operand bytes after the opcode per mode
  always_comb begin
    operand_bytes_o = 2'd0;
    unique case (mode_o)
      oag_pkg::OAG_FULL_ADDRESS_MODE, oag_pkg::OAG_POINTER_WORD_OFFSET_MODE,
      oag_pkg::OAG_BIT_TEST_BRANCH_MODE: operand_bytes_o = 2'd2;
      oag_pkg::OAG_LITERAL_OPERAND_MODE, oag_pkg::OAG_DIRECT_MODE,
      oag_pkg::OAG_POINTER_BYTE_OFFSET_MODE, oag_pkg::OAG_BRANCH_OFFSET_MODE,
      oag_pkg::OAG_SINGLE_BIT_MODIFY_MODE: operand_bytes_o = 2'd1;
      default: operand_bytes_o = 2'd0;
    endcase
  end
endmodule : oag_mode_decode

/* bench/oag_top_sva.sv */
// checker: port timing and address relations of the operand address generator
`timescale 1ns/1ps
module oag_top_sva (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire oag_pkg::oag_req_t req_i,
  input wire logic busy_o,
  input wire logic mem_req_o,
  input wire oag_pkg::oag_mem_t mem_o,
  input wire logic [15:0] pc_o,
  input wire logic [15:0] ea_o,
  input wire logic done_o,
  input wire logic carry_o,
  input wire logic carry_we_o
);
  logic take;
  logic [3:0] hi;
  // an accepted request and the nibble that picks its mode
  assign take = clk_en_i && start_i && !busy_o;
  assign hi = req_i.opcode[7:4];
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ea; done_o && mem_req_o |-> mem_o.addr == ea_o; endproperty
  a_ea: assert property (p_ea) else $error("data access not at effective address");
  property p_inh; take && hi == 4'h4 |-> ##2 done_o && pc_o == $past(pc_o, 2) + 16'h0001; endproperty
  a_inh: assert property (p_inh) else $error("implied step wrong");
  property p_imm; take && hi == 4'ha |-> ##3 done_o && ea_o == $past(pc_o, 3) + 16'h0001; endproperty
  a_imm: assert property (p_imm) else $error("literal address wrong");
  property p_dir; take && hi == 4'hb |-> ##3 ea_o[15:8] == 8'h00 && pc_o == $past(pc_o, 3) + 16'h0002; endproperty
  a_dir: assert property (p_dir) else $error("direct address or step wrong");
  property p_ext; take && hi == 4'hc |-> ##4 done_o && pc_o == $past(pc_o, 4) + 16'h0003; endproperty
  a_ext: assert property (p_ext) else $error("full address step wrong");
  property p_ix; take && hi == 4'hf |-> ##2 ea_o == {8'h00, $past(req_i.index, 2)}; endproperty
  a_ix: assert property (p_ix) else $error("pointer address wrong");
  property p_ix1; take && hi == 4'he |-> ##3 ea_o <= 16'h01fe && ea_o >= {8'h00, $past(req_i.index, 3)}; endproperty
  a_ix1: assert property (p_ix1) else $error("byte offset address out of range");
  property p_ix2; take && hi == 4'hd |-> ##4 done_o && pc_o == $past(pc_o, 4) + 16'h0003; endproperty
  a_ix2: assert property (p_ix2) else $error("word offset step wrong");
  property p_rel; take && hi == 4'h2 && !req_i.cond_true |-> ##3 pc_o == $past(pc_o, 3) + 16'h0002; endproperty
  a_rel: assert property (p_rel) else $error("untaken branch step wrong");
  property p_bsc; take && hi == 4'h1 |-> ##3 mem_req_o && mem_o.write && mem_o.addr[15:8] == 8'h00; endproperty
  a_bsc: assert property (p_bsc) else $error("bit modify write wrong");
  property p_btb; take && hi == 4'h0 |-> ##4 carry_we_o && carry_o == $past(req_i.bit_value, 4); endproperty
  a_btb: assert property (p_btb) else $error("tested bit not written to carry");
endmodule : oag_top_sva

/* bench/oag_mem_model.sv */
// model of the memory answering the generator's bus requests
`timescale 1ns/1ps
module oag_mem_model (
  input wire logic sys_clk_i,
  input wire logic mem_req_i,
  input wire oag_pkg::oag_mem_t mem_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:255];
  // writes land at the edge that sees the request
  always @(posedge sys_clk_i) begin
    if (mem_req_i && mem_i.write) begin
      mem[mem_i.addr[7:0]] <= mem_i.wdata;
    end
  end
  // read data stand while the read request stands, as the generator samples them at its next edge
  // with no read pending the line shows the inverse, so stale data never looks valid
  assign rdata_o = (mem_req_i && !mem_i.write) ? mem[mem_i.addr[7:0]] : ~mem[mem_i.addr[7:0]];
endmodule : oag_mem_model

/* bench/oag_top_test.sv */
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module oag_top_test;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic [7:0] acc_i = 8'h00;
  oag_pkg::oag_req_t req_i = '0;
  oag_pkg::oag_mem_t mem;
  logic [7:0] rdata, operand;
  logic busy, mem_req, op_valid, carry, carry_we, done;
  logic [15:0] pc, ea;
  logic [15:0] pc_e = 16'h0000;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  oag_top i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .start_i(start_i), .req_i(req_i),
    .acc_i(acc_i), .rdata_i(rdata), .busy_o(busy), .mem_req_o(mem_req), .mem_o(mem), .pc_o(pc), .ea_o(ea),
    .operand_o(operand), .operand_valid_o(op_valid), .carry_o(carry), .carry_we_o(carry_we), .done_o(done));
  oag_mem_model i_mem (.sys_clk_i(sys_clk_i), .mem_req_i(mem_req), .mem_i(mem), .rdata_o(rdata));
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // cut a hang short; the whole run needs under a hundred cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
  endtask : wait_idle
  // operand bytes go in memory at pc+1 and pc+2; tested bit value rides on index bit 0
  task op(input logic [7:0] opc, input logic [7:0] idx, input logic cond, input logic [7:0] b1, input logic [7:0] b2);
    int n;
    i_mem.mem[pc_e[7:0] + 8'h01] = b1;
    i_mem.mem[pc_e[7:0] + 8'h02] = b2;
    start_i = 1'b1;
    req_i = '{opc, idx, cond, idx[0]};
    @(posedge sys_clk_i);
    #1;
    start_i = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk("done", 16'h0001, {15'h0000, done});
    wait_idle();
  endtask : op
  task t_inh;
    op(8'h4c, 8'h00, 1'b0, 8'h00, 8'h00);
    pc_e = pc_e + 16'h0001;
    chk("pc", pc_e, pc);
  endtask : t_inh
  task t_imm;
    op(8'ha6, 8'h00, 1'b0, 8'h5e, 8'h00);
    chk("ea", pc_e + 16'h0001, ea);
    chk("operand", 16'h005e, {8'h00, operand});
    chk("operand valid", 16'h0001, {15'h0000, op_valid});
    pc_e = pc_e + 16'h0002;
    chk("pc", pc_e, pc);
  endtask : t_imm
  task t_mem(input logic [7:0] opc, input logic [7:0] idx, input logic [7:0] b1, input logic [7:0] b2,
    input logic [15:0] exp, input logic [15:0] step);
    op(opc, idx, 1'b0, b1, b2);
    chk("ea", exp, ea);
    pc_e = pc_e + step;
    chk("pc", pc_e, pc);
  endtask : t_mem
  // direct read: the argument must come from the first-page byte the operand names
  task t_dir;
    i_mem.mem[8'hc4] = 8'h3c;
    t_mem(8'hb6, 8'h00, 8'hc4, 8'h00, 16'h00c4, 16'h0002);
    chk("operand", 16'h003c, {8'h00, operand});
  endtask : t_dir
  // clock enable low: a start is not taken and the program counter holds
  task t_freeze;
    clk_en_i = 1'b0;
    start_i = 1'b1;
    req_i = '{8'h4c, 8'h00, 1'b0, 1'b0};
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("busy frozen", 16'h0000, {15'h0000, busy});
    chk("pc frozen", pc_e, pc);
    start_i = 1'b0;
    clk_en_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
  endtask : t_freeze
  task t_btb;
    op(8'h00, 8'h01, 1'b0, 8'h20, 8'h05);
    chk("carry", 16'h0001, {15'h0000, carry});
  endtask : t_btb
  task t_rel;
    op(8'h20, 8'h00, 1'b1, 8'hfc, 8'h00);
    pc_e = pc_e - 16'h0002;
    chk("pc taken", pc_e, pc);
    op(8'h26, 8'h00, 1'b0, 8'h10, 8'h00);
    pc_e = pc_e + 16'h0002;
    chk("pc untaken", pc_e, pc);
  endtask : t_rel
  task t_bsc(input logic [7:0] opc, input logic [7:0] acc, input logic [7:0] b1, input logic [7:0] exp);
    acc_i = acc;
    op(opc, 8'h00, 1'b0, b1, 8'h00);
    chk("write addr", {8'h00, b1}, mem.addr);
    chk("write data", {8'h00, exp}, {8'h00, mem.wdata});
    pc_e = pc_e + 16'h0002;
    chk("pc", pc_e, pc);
  endtask : t_bsc
  initial begin
    repeat (8) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_inh();
    t_imm();
    t_dir();
    t_mem(8'hc6, 8'h00, 8'h12, 8'h34, 16'h1234, 16'h0003);
    t_mem(8'hf6, 8'h80, 8'h00, 8'h00, 16'h0080, 16'h0001);
    t_mem(8'he6, 8'hff, 8'hff, 8'h00, 16'h01fe, 16'h0002);
    t_mem(8'hd6, 8'h90, 8'h12, 8'h80, 16'h1310, 16'h0003);
    t_rel();
    t_bsc(8'h14, 8'h00, 8'h33, 8'h04);
    t_bsc(8'h17, 8'hff, 8'h44, 8'hf7);
    t_freeze();
    t_btb();
    give_verdict();
  end
endmodule : oag_top_test
bind oag_top oag_top_sva i_sva (.sys_clk_i, .rst_n_i, .clk_en_i, .start_i, .req_i, .busy_o, .mem_req_o, .mem_o,
  .pc_o, .ea_o, .done_o, .carry_o, .carry_we_o);
